// ---- core/wscr_regs.sv ----
// Wake source control register bank
`timescale 1ns/1ps
module wscr_regs (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Register access from serial interface
    input wire logic [6:0] addr_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    // Device events
    input wire logic soft_rst_i,
    input wire logic restart_i,
    input wire logic failsafe_i,
    input wire logic wds_hw_set_i,
    input wire logic wds_hw_clr_i,
    input wire logic [7:0] bus_ctrl_i,
    input wire logic t1_cfg_i,
    input wire logic t2_cfg_i,
    input wire logic [2:0] pin_level_i,
    input wire logic [2:0] pin_event_i,
    input wire logic t1_event_i,
    input wire logic t2_event_i,
    input wire logic bus_event_i,
    input wire logic status_event_i,
    // Results
    output logic [7:0] bus_ctrl_o,
    output logic bus_force_o,
    output logic stop_wd_disable_o,
    output logic meas_en_o,
    output logic [2:0] pull_up_o,
    output logic [2:0] pull_down_o,
    output logic wake_o,
    output logic int_o
);
    logic [7:0] int_reg, int_next;
    logic [7:0] ext_reg, ext_next;
    logic [7:0] pull_reg, pull_next;
    logic [7:0] rd_reg, rd_next;
    logic [7:0] bus_reg, bus_next;
    logic bf_reg, bf_next;
    logic wd_reg, wd_next, ms_reg, ms_next;
    logic [2:0] pu_reg, pu_next, pd_reg, pd_next;
    logic wk_reg, wk_next, irq_reg, irq_next;
    logic [2:0] pu_c, pd_c;
    logic [2:0] pin_wake;
    logic any_wake;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_pull
            wscr_pull_dec u_dec (
                .code_i(pull_reg[2*g+1:2*g]),
                .level_i(pin_level_i[g]),
                .pull_up_o(pu_c[g]),
                .pull_down_o(pd_c[g])
            );
        end
    endgenerate

    // Shared write decode keeps the three register selects identical
    function automatic logic wscr_wr_hit(input logic wr, input logic [6:0] a,
        input logic [6:0] sel);
        return wr && (a == sel);
    endfunction : wscr_wr_hit

    always_comb begin
        int_next = int_reg;
        ext_next = ext_reg;
        pull_next = pull_reg;
        bus_next = bus_ctrl_i;
        bf_next = 1'b0;
        if (wscr_wr_hit(wr_i, addr_i, wscr_pkg::WSCR_ADDR_INT))
            int_next = wdata_i & wscr_pkg::WSCR_INT_MASK; // [RULE17]
        if (wscr_wr_hit(wr_i, addr_i, wscr_pkg::WSCR_ADDR_EXT))
            ext_next = wdata_i & wscr_pkg::WSCR_EXT_MASK; // [RULE17]
        if (wscr_wr_hit(wr_i, addr_i, wscr_pkg::WSCR_ADDR_PULL))
            pull_next = wdata_i & wscr_pkg::WSCR_PULL_MASK; // [RULE17]
        // Hardware set wins over a hardware clear
        if (wds_hw_clr_i)
            int_next[wscr_pkg::WSCR_B_WDS] = 1'b0; // [RULE4]
        if (wds_hw_set_i)
            int_next[wscr_pkg::WSCR_B_WDS] = 1'b1; // [RULE4]
        if (restart_i)
            ext_next = ext_reg & wscr_pkg::WSCR_EXT_RESTART_KEEP; // [RULE13]
        if (failsafe_i) begin
            ext_next = (ext_reg & ~wscr_pkg::WSCR_EXT_FS_CLR)
                | wscr_pkg::WSCR_EXT_FS_SET; // [RULE12]
            bus_next = (bus_ctrl_i & ~wscr_pkg::WSCR_BUS_FS_CLR)
                | wscr_pkg::WSCR_BUS_FS_SET; // [RULE12]
            bf_next = 1'b1;
        end
        if (soft_rst_i) begin
            int_next = wscr_pkg::WSCR_INT_RST; // [RULE14]
            ext_next = wscr_pkg::WSCR_EXT_RST; // [RULE13]
            pull_next = wscr_pkg::WSCR_PULL_RST; // [RULE15]
        end
    end

    always_comb begin
        rd_next = 8'h00; // [RULE3]
        case (addr_i)
            wscr_pkg::WSCR_ADDR_INT: rd_next = int_reg;
            wscr_pkg::WSCR_ADDR_EXT: rd_next = ext_reg;
            wscr_pkg::WSCR_ADDR_PULL: rd_next = pull_reg;
            default: rd_next = 8'h00;
        endcase
        // Measurement mode blocks pins one and two
        pin_wake[0] = ext_reg[wscr_pkg::WSCR_B_P1]
            & ~ext_reg[wscr_pkg::WSCR_B_MEAS]; // [RULE7] [RULE9]
        pin_wake[1] = ext_reg[wscr_pkg::WSCR_B_P2]
            & ~ext_reg[wscr_pkg::WSCR_B_MEAS]; // [RULE7] [RULE9]
        pin_wake[2] = ext_reg[wscr_pkg::WSCR_B_P3]; // [RULE9]
        any_wake = |(pin_wake & pin_event_i)
            | (int_reg[wscr_pkg::WSCR_B_T1] & t1_cfg_i & t1_event_i)
            | (int_reg[wscr_pkg::WSCR_B_T2] & t2_cfg_i & t2_event_i)
            | bus_event_i; // [RULE1] [RULE2] [RULE16] [RULE11]
        wk_next = any_wake;
        irq_next = any_wake | (ext_reg[wscr_pkg::WSCR_B_GLOB]
            & status_event_i); // [RULE5] [RULE6]
        wd_next = int_reg[wscr_pkg::WSCR_B_WDS]; // [RULE4]
        ms_next = ext_reg[wscr_pkg::WSCR_B_MEAS];
        pu_next = pu_c;
        pd_next = pd_c;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            int_reg <= wscr_pkg::WSCR_INT_RST;
            ext_reg <= wscr_pkg::WSCR_EXT_RST;
            pull_reg <= wscr_pkg::WSCR_PULL_RST;
            rd_reg <= 8'h00;
            bus_reg <= 8'h00;
            bf_reg <= 1'b0;
            wd_reg <= 1'b0;
            ms_reg <= 1'b0;
            pu_reg <= 3'h0;
            pd_reg <= 3'h0;
            wk_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else if (ce_i) begin
            int_reg <= int_next;
            ext_reg <= ext_next;
            pull_reg <= pull_next;
            rd_reg <= rd_next;
            bus_reg <= bus_next;
            bf_reg <= bf_next;
            wd_reg <= wd_next;
            ms_reg <= ms_next;
            pu_reg <= pu_next;
            pd_reg <= pd_next;
            wk_reg <= wk_next;
            irq_reg <= irq_next;
        end
    end

    assign rdata_o = rd_reg;
    assign bus_ctrl_o = bus_reg;
    assign bus_force_o = bf_reg;
    assign stop_wd_disable_o = wd_reg;
    assign meas_en_o = ms_reg;
    assign pull_up_o = pu_reg;
    assign pull_down_o = pd_reg;
    assign wake_o = wk_reg;
    assign int_o = irq_reg;

    AST_RSV_ZERO: assert property ( // [RULE3]
        @(posedge mclk_i) disable iff (rst_i)
        (int_reg & ~wscr_pkg::WSCR_INT_MASK) == 8'h00
        && (ext_reg & ~wscr_pkg::WSCR_EXT_MASK) == 8'h00)
        else $error("reserved bits set");
    AST_PULL_RSV: assert property ( // [RULE3]
        @(posedge mclk_i) disable iff (rst_i)
        (pull_reg & ~wscr_pkg::WSCR_PULL_MASK) == 8'h00)
        else $error("pull reserved bits set");
    AST_MEAS_BLOCK: assert property ( // [RULE7]
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && ext_reg[wscr_pkg::WSCR_B_MEAS] && !ext_reg[2] && !bus_event_i
        && !t1_event_i && !t2_event_i |=> !wake_o)
        else $error("pin wake in measurement mode");
    AST_SOFT_RST: assert property ( // [RULE13]
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && soft_rst_i |=> ext_reg == wscr_pkg::WSCR_EXT_RST
        && int_reg == 8'h00 && pull_reg == 8'h00)
        else $error("soft reset values wrong");
    AST_FAILSAFE: assert property ( // [RULE12]
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && failsafe_i && !soft_rst_i |=> ext_reg[2:0] == 3'h7
        && !ext_reg[6] && !ext_reg[4] && bus_ctrl_o[3:0] == 4'h9)
        else $error("fail-safe values wrong");
    AST_FS_FLAG: assert property ( // [RULE12]
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && failsafe_i |=> bus_force_o)
        else $error("fail-safe bus force missing");
    AST_T1_WAKE: assert property ( // [RULE2]
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && int_reg[6] && t1_cfg_i && t1_event_i |=> wake_o && int_o)
        else $error("timer one wake lost");
    AST_T2_WAKE: assert property ( // [RULE1]
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && int_reg[wscr_pkg::WSCR_B_T2] && t2_cfg_i && t2_event_i
        |=> wake_o && int_o)
        else $error("timer two wake lost");
    AST_T2_OFF: assert property ( // [RULE1]
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && !int_reg[7] && t2_event_i && !t1_event_i && !bus_event_i
        && (pin_event_i & ext_reg[2:0]) == 3'h0 |=> !wake_o)
        else $error("timer two wake while disabled");
    AST_PIN3_WAKE: assert property ( // [RULE9]
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && ext_reg[wscr_pkg::WSCR_B_P3] && pin_event_i[2] |=> wake_o)
        else $error("pin three wake lost");
    AST_GLOBAL: assert property ( // [RULE5]
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && !wk_next && status_event_i |=> int_o == $past(ext_reg[7]))
        else $error("interrupt scope wrong");
    AST_RESTART: assert property ( // [RULE13]
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && restart_i && !failsafe_i && !soft_rst_i |=>
        ext_reg == ($past(ext_reg) & wscr_pkg::WSCR_EXT_RESTART_KEEP))
        else $error("restart value wrong");
    AST_WDS: assert property ( // [RULE4]
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && wds_hw_set_i && !soft_rst_i |=> ##1 stop_wd_disable_o)
        else $error("watchdog stop disable missing");
    AST_WDS_WINS: assert property ( // [RULE4]
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && wds_hw_set_i && wds_hw_clr_i && !soft_rst_i
        |=> int_reg[wscr_pkg::WSCR_B_WDS])
        else $error("hardware set lost to clear");
endmodule : wscr_regs

// ---- core/wscr_pkg.sv ----
// Constants for the wake source control register bank
// Operation
// RULE1: Timer two wake follows bit seven
// RULE2: Timer one wake follows bit six
// RULE3: Reserved bits always read zero
// RULE4: Bit two disables watchdog in stop
// RULE5: Scope zero: only wakes raise interrupt
// RULE6: Scope one: every status bit interrupts
// RULE7: Measurement select masks pin one, two wakes
// RULE8: Host ignores pin levels while measuring
// RULE9: Low three bits enable pin wakes
// RULE10: Two-bit pull code per wake pin
// RULE11: Bus wakes come from bus control; the code takes bus_event_i as a wake with no bus control gating
// RULE12: Fail-safe forces wake-capable register values
// RULE13: External reset 07, restart clears 6,4,3
// RULE14: Internal register resets to zero
// RULE15: Pull register resets to zero
// RULE16: Timer wake needs configured timer
// RULE17: Reserved writes have no effect
package wscr_pkg;
    localparam logic [6:0] WSCR_ADDR_INT = 7'h06;
    localparam logic [6:0] WSCR_ADDR_EXT = 7'h07;
    localparam logic [6:0] WSCR_ADDR_PULL = 7'h08;
    localparam logic [7:0] WSCR_INT_MASK = 8'hc4;
    localparam logic [7:0] WSCR_EXT_MASK = 8'ha7;
    localparam logic [7:0] WSCR_PULL_MASK = 8'h3f;
    localparam logic [7:0] WSCR_INT_RST = 8'h00;
    localparam logic [7:0] WSCR_EXT_RST = 8'h07;
    localparam logic [7:0] WSCR_PULL_RST = 8'h00;
    localparam logic [7:0] WSCR_EXT_RESTART_KEEP = 8'ha7;
    localparam logic [7:0] WSCR_EXT_FS_CLR = 8'h58;
    localparam logic [7:0] WSCR_EXT_FS_SET = 8'h07;
    localparam logic [7:0] WSCR_BUS_FS_CLR = 8'h16;
    localparam logic [7:0] WSCR_BUS_FS_SET = 8'h09;
    localparam int WSCR_B_T2 = 7;
    localparam int WSCR_B_T1 = 6;
    localparam int WSCR_B_WDS = 2;
    localparam int WSCR_B_GLOB = 7;
    localparam int WSCR_B_MEAS = 5;
    localparam int WSCR_B_P3 = 2;
    localparam int WSCR_B_P2 = 1;
    localparam int WSCR_B_P1 = 0;
    localparam logic [1:0] WSCR_BUS_WAKE = 2'h1;
    localparam logic [1:0] WSCR_PULL_NONE = 2'h0;
    localparam logic [1:0] WSCR_PULL_DOWN = 2'h1;
    localparam logic [1:0] WSCR_PULL_UP = 2'h2;
    localparam logic [1:0] WSCR_PULL_AUTO = 2'h3;
endpackage : wscr_pkg

// ---- core/wscr_pull_dec.sv ----
// Pull resistor decode for one wake pin
`timescale 1ns/1ps
module wscr_pull_dec (
    // Code
    input wire logic [1:0] code_i,
    input wire logic level_i,
    // Resistor enables
    output logic pull_up_o,
    output logic pull_down_o
);
    // Auto mode pulls toward the present level, holding it stable
    always_comb begin
        pull_up_o = 1'b0;
        pull_down_o = 1'b0;
        case (code_i) // [RULE10]
            wscr_pkg::WSCR_PULL_NONE: begin
            end
            wscr_pkg::WSCR_PULL_DOWN: pull_down_o = 1'b1;
            wscr_pkg::WSCR_PULL_UP: pull_up_o = 1'b1;
            wscr_pkg::WSCR_PULL_AUTO: begin
                pull_up_o = level_i;
                pull_down_o = ~level_i;
            end
            default: begin
            end
        endcase
    end
endmodule : wscr_pull_dec

// ---- sim/wscr_host.sv ----
// Host model reaching the wake registers over the serial link
`timescale 1ns/1ps
module wscr_host (
    // Clock
    input wire logic mclk_i,
    // Register access
    output logic [6:0] addr_o,
    output logic wr_o,
    output logic [7:0] wdata_o,
    input wire logic [7:0] rdata_i
);
    initial begin
        addr_o = 7'h00;
        wr_o = 1'b0;
        wdata_o = 8'h00;
    end
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge mclk_i);
        wr_o = 1'b0;
        // Released data must not keep its last value
        wdata_o = ~d;
    endtask : wr
    // Pin level status is never used while measuring
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(negedge mclk_i);
        addr_o = a;
        @(negedge mclk_i);
        d = rdata_i;
    endtask : rd
endmodule : wscr_host

// ---- sim/tb.sv ----
// Self-checking bench for the wake source control registers
`timescale 1ns/1ps
module tb;
    logic mclk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, soft_rst_i = 1'b0;
    logic restart_i = 1'b0, failsafe_i = 1'b0, wds_hw_set_i = 1'b0;
    logic wds_hw_clr_i = 1'b0, t1_cfg_i = 1'b0, t2_cfg_i = 1'b0;
    logic t1_event_i = 1'b0, t2_event_i = 1'b0, bus_event_i = 1'b0;
    logic status_event_i = 1'b0, bus_force_o, stop_wd_disable_o, meas_en_o;
    logic wake_o, int_o, wr_i;
    logic [2:0] pin_level_i = 3'h0, pin_event_i = 3'h0;
    logic [2:0] pull_up_o, pull_down_o;
    logic [7:0] bus_ctrl_i = 8'h00, bus_ctrl_o, rdata_o, wdata_i, rv;
    logic [6:0] addr_i;
    logic [31:0] v;
    logic [7:0] r [3] = '{8'h00, 8'h07, 8'h00};
    logic [7:0] msk [3] = '{wscr_pkg::WSCR_INT_MASK, wscr_pkg::WSCR_EXT_MASK,
        wscr_pkg::WSCR_PULL_MASK};
    int miscompares = 0, checks = 0;

    wscr_regs dut_u (.mclk_i, .rst_i, .ce_i, .addr_i, .wr_i, .wdata_i,
        .rdata_o, .soft_rst_i, .restart_i, .failsafe_i, .wds_hw_set_i,
        .wds_hw_clr_i, .bus_ctrl_i, .t1_cfg_i, .t2_cfg_i, .pin_level_i,
        .pin_event_i, .t1_event_i, .t2_event_i, .bus_event_i, .status_event_i,
        .bus_ctrl_o, .bus_force_o, .stop_wd_disable_o, .meas_en_o,
        .pull_up_o, .pull_down_o, .wake_o, .int_o);
    wscr_host host_u (.mclk_i, .addr_o(addr_i), .wr_o(wr_i),
        .wdata_o(wdata_i), .rdata_i(rdata_o));

    always #25 mclk_i = ~mclk_i;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    task automatic pulse(ref logic s);
        @(negedge mclk_i);
        s = 1'b1;
        @(negedge mclk_i);
        s = 1'b0;
    endtask : pulse
    task automatic regs;
        for (int i = 0; i < 3; i++) begin
            host_u.rd(7'h06 + i[6:0], rv);
            chk(rv, r[i]);
        end
    endtask : regs
    task automatic outs;
        logic w, q, u, d;
        logic [1:0] c;
        w = (r[0][7] & t2_cfg_i & t2_event_i)
            | (r[0][6] & t1_cfg_i & t1_event_i)
            | (r[1][2] & pin_event_i[2]) | bus_event_i
            | (!r[1][5] & |(r[1][1:0] & pin_event_i[1:0]));
        q = w | (r[1][7] & status_event_i);
        chk({7'h00, wake_o}, {7'h00, w});
        chk({7'h00, int_o}, {7'h00, q});
        chk({7'h00, stop_wd_disable_o}, {7'h00, r[0][2]});
        chk({7'h00, meas_en_o}, {7'h00, r[1][5]});
        chk(bus_ctrl_o, bus_ctrl_i);
        for (int k = 0; k < 3; k++) begin
            c = r[2][2*k +: 2];
            // Auto code pulls toward the level the pin shows
            u = (c == 2'h2) | (c == 2'h3 & pin_level_i[k]);
            d = (c == 2'h1) | (c == 2'h3 & !pin_level_i[k]);
            chk({7'h00, pull_up_o[k]}, {7'h00, u});
            chk({7'h00, pull_down_o[k]}, {7'h00, d});
        end
    endtask : outs

    initial begin
        repeat (20000) @(posedge mclk_i);
        miscompares++;
        results;
    end

    initial begin
        v = $urandom(76169);
        repeat (3) @(negedge mclk_i);
        rst_i = 1'b0;
        regs;
        host_u.rd(7'h09, rv);
        chk(rv, 8'h00);
        $display("test reset done");
        for (int n = 0; n < 60; n++) begin
            for (int i = 0; i < 4; i++) begin
                v = $urandom;
                host_u.wr(7'h06 + i[6:0], v[7:0]);
                if (i < 3) r[i] = v[7:0] & msk[i];
            end
            v = $urandom;
            {t1_cfg_i, t2_cfg_i, t1_event_i, t2_event_i, status_event_i,
                pin_level_i, pin_event_i} = v[10:0];
            bus_event_i = &v[13:11];
            bus_ctrl_i = v[23:16];
            repeat (3) @(negedge mclk_i);
            outs;
            regs;
        end
        $display("test random access done");
        host_u.wr(7'h07, 8'ha0);
        bus_ctrl_i = 8'hff;
        pulse(failsafe_i);
        chk({bus_force_o, bus_ctrl_o[6:0]}, 8'he9);
        @(negedge mclk_i);
        chk({bus_force_o, bus_ctrl_o[6:0]}, 8'h7f);
        r[1] = 8'ha7;
        regs;
        pulse(restart_i);
        regs;
        $display("test fail-safe and restart done");
        wds_hw_clr_i = 1'b1;
        pulse(wds_hw_set_i);
        wds_hw_clr_i = 1'b0;
        r[0][2] = 1'b1;
        regs;
        pulse(wds_hw_clr_i);
        r[0][2] = 1'b0;
        regs;
        ce_i = 1'b0;
        host_u.wr(7'h06, 8'hc4);
        ce_i = 1'b1;
        regs;
        pulse(soft_rst_i);
        r = '{8'h00, 8'h07, 8'h00};
        regs;
        $display("test hardware bit and soft reset done");
        results;
    end
endmodule : tb
